// file: core/rcr_consts.svh
// Purpose: Constants for the rolling-code receiver core.
// Assumes: 50 MHz clk; byte addresses on the register bus.
// Notes: Timing counts are derived from the times below.
// Summary of operation
// [R1] Seven slots; learn fills an empty one.
// [R2] All full: overwrite most recently learned slot.
// [R3] Command C3H erases every slot.
// [R4] Command D2H starts learn; data line acknowledges.
// [R5] Learn needs two frames; secure: second is seed.
// [R6] Send learn status string after learn.
// [R7] Abort on nonsequential codes or 30 s.
// [R8] Same key replaces its slot, no new slot.
// [R9] Check integrity, key, decrypt, discrimination, then store.
// [R10] Match serial check, then decrypt with slot key.
// [R11] Discrimination equals serial low 10 bits.
// [R12] Failing slot: try next; valid: update counter.
// [R13] Ahead within 16: store counter, accept.
// [R14] Within 16K: hold temporarily, reject, wait.
// [R15] Sequential with held counter: resync, accept.
// [R16] Reject beyond window; window moves on accept.
// [R17] Valid frame: data high up to 500 ms.
// [R18] Host raises clock; device drives data low.
// [R19] Header: start, flags, function, stop, count, slot.
// [R20] Then 64 frame bits with decrypted hop.
// [R21] Link bits go least significant first.
// [R22] End on clock low over 1 ms; max 80.
// [R23] Data placed on rise, sampled on fall.
// [R24] Window uses 16-bit forward difference mod 65536.
// [R25] Held counter dropped on small-window accept.
`ifndef RCR_CONSTS_SVH
`define RCR_CONSTS_SVH
`define RCR_CLK_HZ 50000000
`define RCR_LEARN_TIMEOUT_S 30
`define RCR_NOTIFY_MS 500
`define RCR_IDLE_MS 1
`define RCR_ACK_MS 1
`define RCR_SLOTS 7
`define RCR_MSG_BITS 80
`define RCR_SMALL_WIN 16'h0010
`define RCR_LARGE_WIN 16'h4000
`define RCR_CMD_ERASE 8'hC3
`define RCR_CMD_LEARN 8'hD2
`define RCR_REG_CTRL 3'h0
`define RCR_REG_CMD 3'h1
`define RCR_REG_MFR_LO 3'h2
`define RCR_REG_MFR_HI 3'h3
`define RCR_CTRL_SECURE 0
`endif

// file: core/rcr_core.sv
// Purpose: Rolling-code receiver: learn, validate, notify the host.
// Assumes: Frames arrive one at a time with an integrity flag.
// Notes: Host clock is asynchronous and sampled through two flops.
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "rcr_consts.svh"
module rcr_core #(
  parameter int LEARN_TO_CYC = `RCR_LEARN_TIMEOUT_S * `RCR_CLK_HZ,
  parameter int NOTIFY_CYC = `RCR_NOTIFY_MS * (`RCR_CLK_HZ / 1000),
  parameter int IDLE_CYC = `RCR_IDLE_MS * (`RCR_CLK_HZ / 1000),
  parameter int ACK_CYC = `RCR_ACK_MS * (`RCR_CLK_HZ / 1000)
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_valid,
  input wire logic rx_intact,
  input wire rcr_pkg::rcr_frame_t rx_frame,
  input wire logic host_serial_clk,
  input wire logic host_serial_data_in,
  output logic host_serial_data_out,
  output logic host_serial_data_oe
);
  import rcr_pkg::*;

  // ==========================================================
  // Pin synchronisers
  // The host clock and data pins run on the host's own timing.
  // Two flops settle them before any logic looks at them.
  // A third flop on the clock gives the edge detector its history.
  logic hclk_s1, hclk_s2, hclk_d, hdat_s1, hdat_s2;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hclk_s1 <= 1'b0;
      hclk_s2 <= 1'b0;
      hclk_d <= 1'b0;
      hdat_s1 <= 1'b0;
      hdat_s2 <= 1'b0;
    end else begin
      hclk_s1 <= host_serial_clk;
      hclk_s2 <= hclk_s1;
      hclk_d <= hclk_s2;
      hdat_s1 <= host_serial_data_in;
      hdat_s2 <= hdat_s1;
    end
  end
  logic hclk_rise;
  assign hclk_rise = hclk_s2 & ~hclk_d;

  // ==========================================================
  // Register bus slave, one wait state per access
  // Every access is held for exactly one wait state.
  // Read data is loaded on the first edge and stands on the second.
  // Writes and commands take effect only on the second edge.
  // Command codes other than erase and learn are ignored.
  logic bus_ack, secure, last_result;
  logic [63:0] mfr;
  logic wr_take, erase_cmd, learn_cmd;
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
  assign wr_take = avs_write & bus_ack;
  assign erase_cmd = wr_take && avs_address[4:2] == `RCR_REG_CMD &&
                     avs_writedata[7:0] == `RCR_CMD_ERASE; // see [R3]
  assign learn_cmd = wr_take && avs_address[4:2] == `RCR_REG_CMD &&
                     avs_writedata[7:0] == `RCR_CMD_LEARN; // see [R4]

  rcr_learn_t lstate;
  rcr_link_t kstate;
  logic [3:0] used_count;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) bus_ack <= 1'b0;
    else bus_ack <= (avs_read | avs_write) & ~bus_ack;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      secure <= 1'b0;
      mfr <= 64'h0;
    end else if (wr_take) begin
      case (avs_address[4:2])
        `RCR_REG_CTRL: secure <= avs_writedata[`RCR_CTRL_SECURE];
        `RCR_REG_MFR_LO: mfr[31:0] <= avs_writedata;
        `RCR_REG_MFR_HI: mfr[63:32] <= avs_writedata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) avs_readdata <= 32'h0;
    else if (avs_read & ~bus_ack) begin
      case (avs_address[4:2])
        `RCR_REG_CTRL: avs_readdata <= {31'h0, secure};
        `RCR_REG_CMD: avs_readdata <= {24'h0, hdat_s2, kstate != LK_IDLE,
                                       last_result, lstate != LN_IDLE, used_count};
        `RCR_REG_MFR_LO: avs_readdata <= mfr[31:0];
        `RCR_REG_MFR_HI: avs_readdata <= mfr[63:32];
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

  // ==========================================================
  // Transmitter slots
  // Each slot keeps a key, a serial check value and a counter.
  // A second counter holds a candidate for resynchronisation.
  // Erase clears the used and held flags only; stale contents are never read.
  // The enrolled count is the number of used flags that are set.
  logic [`RCR_SLOTS-1:0] used, temp_ok;
  logic [63:0] slot_key [`RCR_SLOTS];
  logic [27:0] slot_ser [`RCR_SLOTS];
  logic [15:0] slot_cnt [`RCR_SLOTS];
  logic [15:0] slot_tmp [`RCR_SLOTS];
  logic [2:0] last_idx;

  always_comb begin
    used_count = 4'h0;
    for (int i = 0; i < `RCR_SLOTS; i++) used_count = used_count + {3'h0, used[i]};
  end

  // ==========================================================
  // Learn checks on the second frame
  // The first frame is kept and judged when the second one arrives.
  // A matching key reuses its slot, otherwise the lowest empty slot is taken.
  // When every slot is in use the most recently learned slot is reused.
  // The overwrite flag reports either kind of reuse to the host.
  rcr_frame_t lf;
  logic [63:0] lkey;
  logic [31:0] d1, d2;
  logic lok, match_hit, empty_hit, ovr, learn_store;
  logic [2:0] match_idx, empty_idx, sidx;
  logic [15:0] lcnt;
  logic [3:0] count_after;

  always_comb begin
    lkey = rcr_keygen(mfr, lf.serial, rx_frame.hop, secure); // see [R5]
    d1 = rcr_decrypt(lkey, lf.hop);
    d2 = rcr_decrypt(lkey, rx_frame.hop);
    lok = rx_intact && lf.serial == rx_frame.serial &&
          d1[25:16] == lf.serial[9:0]; // see [R9]
    if (!secure) lok = lok && d2[25:16] == lf.serial[9:0] &&
                       d2[15:0] == d1[15:0] + 16'h0001; // see [R7]
    lcnt = secure ? d1[15:0] : d2[15:0];
    match_hit = 1'b0;
    match_idx = 3'h0;
    empty_hit = 1'b0;
    empty_idx = 3'h0;
    for (int i = `RCR_SLOTS - 1; i >= 0; i--) begin
      if (used[i] && slot_key[i] == lkey) begin
        match_hit = 1'b1; // see [R8]
        match_idx = 3'(i);
      end
      if (!used[i]) begin
        empty_hit = 1'b1; // see [R1]
        empty_idx = 3'(i);
      end
    end
    sidx = match_hit ? match_idx : (empty_hit ? empty_idx : last_idx); // see [R2]
    ovr = match_hit | ~empty_hit;
    count_after = used_count + {3'h0, ~ovr};
  end
  assign learn_store = lstate == LN_SECOND && rx_valid && lok;

  // ==========================================================
  // Validation scan over slots
  // One slot is tried per cycle, so a scan takes at most seven cycles.
  // The counter difference is taken modulo the counter width.
  // A zero difference is a replayed code and is never accepted.
  // Frames that arrive while a scan runs are dropped.
  rcr_val_t vstate;
  rcr_frame_t vf;
  logic [2:0] vidx;
  logic [31:0] vdec;
  logic [15:0] vdiff;
  logic cand, v_accept, v_hold;

  always_comb begin
    vdec = rcr_decrypt(slot_key[vidx], vf.hop); // see [R10]
    vdiff = vdec[15:0] - slot_cnt[vidx]; // see [R24]
    cand = vstate == V_SCAN && used[vidx] && slot_ser[vidx] == vf.serial &&
           vdec[25:16] == vf.serial[9:0]; // see [R11]
    v_accept = 1'b0;
    v_hold = 1'b0;
    if (cand && vdiff != 16'h0 && vdiff <= `RCR_SMALL_WIN) v_accept = 1'b1; // see [R13]
    else if (cand && vdiff != 16'h0 && vdiff < `RCR_LARGE_WIN) begin
      if (temp_ok[vidx] && vdec[15:0] == slot_tmp[vidx] + 16'h0001)
        v_accept = 1'b1; // see [R15]
      else v_hold = 1'b1; // see [R14]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vstate <= V_IDLE;
      vidx <= 3'h0;
      vf <= '0;
    end else begin
      case (vstate)
        V_IDLE: if (rx_valid && rx_intact && lstate == LN_IDLE) begin
          vf <= rx_frame;
          vidx <= 3'h0;
          vstate <= V_SCAN;
        end
        V_SCAN: begin
          if (v_accept || v_hold || vidx == 3'(`RCR_SLOTS - 1)) vstate <= V_IDLE; // see [R16]
          else vidx <= vidx + 3'h1; // see [R12]
        end
        default: vstate <= V_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      used <= '0;
      temp_ok <= '0;
      last_idx <= 3'h0;
      for (int i = 0; i < `RCR_SLOTS; i++) begin
        slot_key[i] <= 64'h0;
        slot_ser[i] <= 28'h0;
        slot_cnt[i] <= 16'h0;
        slot_tmp[i] <= 16'h0;
      end
    end else if (erase_cmd) begin
      used <= '0; // see [R3]
      temp_ok <= '0;
    end else if (learn_store) begin
      used[sidx] <= 1'b1; // see [R9]
      temp_ok[sidx] <= 1'b0;
      slot_key[sidx] <= lkey;
      slot_ser[sidx] <= lf.serial;
      slot_cnt[sidx] <= lcnt;
      last_idx <= sidx;
    end else if (v_accept) begin
      slot_cnt[vidx] <= vdec[15:0]; // see [R12]
      temp_ok[vidx] <= 1'b0; // see [R25]
    end else if (v_hold) begin
      slot_tmp[vidx] <= vdec[15:0];
      temp_ok[vidx] <= 1'b1;
    end
  end

  // ==========================================================
  // Learn sequencer
  // The timer runs from the learn command until both frames are judged.
  // A timeout before the first frame or a damaged first frame ends learn without a message.
  // A damaged or failing second frame still sends a status string.
  // Erase always ends a learn that is in progress.
  logic [31:0] ltmr;
  logic learn_end;
  assign learn_end = (lstate == LN_FIRST && rx_valid && !rx_intact) ||
                     (lstate != LN_IDLE && ltmr == 32'(LEARN_TO_CYC - 1)); // see [R7]

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lstate <= LN_IDLE;
      ltmr <= 32'h0;
      lf <= '0;
      last_result <= 1'b0;
    end else if (learn_cmd) begin
      lstate <= LN_FIRST; // see [R4]
      ltmr <= 32'h0;
    end else if (erase_cmd) lstate <= LN_IDLE;
    else begin
      ltmr <= ltmr + 32'h1;
      case (lstate)
        LN_FIRST: if (learn_end) begin
          lstate <= LN_IDLE;
          last_result <= 1'b0;
        end else if (rx_valid) begin
          lf <= rx_frame; // see [R5]
          lstate <= LN_SECOND;
        end
        LN_SECOND: if (rx_valid || learn_end) begin
          lstate <= LN_IDLE;
          last_result <= learn_store;
        end
        default: lstate <= LN_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Message composer, bit 0 is sent first
  // A valid reception and a learn result meet in one cycle only if learn starts mid-scan; the reception wins.
  // Learning blocks new scans only; a scan already running when learn starts still finishes.
  // A message that arrives while the link is busy is lost.
  logic msg_req;
  logic [`RCR_MSG_BITS-1:0] msg;
  always_comb begin
    msg_req = 1'b0;
    msg = '0;
    if (v_accept) begin
      msg_req = 1'b1; // see [R17]
      msg = {vf.button_function_code, vf.serial, vdec, 1'b0, vidx, used_count, 1'b1,
             vf.button_function_code, vf.low_battery_flag, vf.repeat_press,
             1'b0}; // see [R19] see [R20]
    end else if (lstate == LN_SECOND && (rx_valid || learn_end)) begin
      msg_req = 1'b1; // see [R6]
      msg = {64'h0, 1'b0, sidx, learn_store ? count_after : used_count, 1'b1, 4'h0,
             learn_store & ovr, learn_store, 1'b0};
    end
  end

  // ==========================================================
  // Host link: notify, acknowledge, shift out
  // The first host clock rise only acknowledges the notify.
  // Each later rise puts the next message bit on the data line.
  // A long low clock or a rise after the last bit releases the line.
  // The data line is driven only during a transfer or the acknowledge after a learn command.
  logic [`RCR_MSG_BITS-1:0] sh;
  logic [6:0] bitcnt;
  logic [31:0] ktmr;
  logic [31:0] acnt;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) acnt <= 32'h0;
    else if (learn_cmd) acnt <= 32'(ACK_CYC); // see [R4]
    else if (acnt != 32'h0) acnt <= acnt - 32'h1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      kstate <= LK_IDLE;
      sh <= '0;
      bitcnt <= 7'h0;
      ktmr <= 32'h0;
      host_serial_data_out <= 1'b0;
      host_serial_data_oe <= 1'b0;
    end else begin
      case (kstate)
        LK_IDLE: begin
          host_serial_data_out <= acnt != 32'h0;
          host_serial_data_oe <= acnt != 32'h0;
          ktmr <= 32'h0;
          if (msg_req) begin
            sh <= msg;
            kstate <= LK_NOTIFY;
            host_serial_data_out <= 1'b1; // see [R17]
            host_serial_data_oe <= 1'b1;
          end
        end
        LK_NOTIFY: begin
          ktmr <= ktmr + 32'h1;
          if (hclk_rise) begin
            kstate <= LK_SHIFT; // see [R18]
            host_serial_data_out <= 1'b0;
            bitcnt <= 7'h0;
            ktmr <= 32'h0;
          end else if (ktmr == 32'(NOTIFY_CYC - 1)) begin
            kstate <= LK_IDLE;
            host_serial_data_out <= 1'b0;
            host_serial_data_oe <= 1'b0;
          end
        end
        LK_SHIFT: begin
          ktmr <= hclk_s2 ? 32'h0 : ktmr + 32'h1;
          if (ktmr == 32'(IDLE_CYC - 1) ||
              (hclk_rise && bitcnt == 7'(`RCR_MSG_BITS))) begin
            kstate <= LK_IDLE; // see [R22]
            host_serial_data_out <= 1'b0;
            host_serial_data_oe <= 1'b0;
          end else if (hclk_rise) begin
            host_serial_data_out <= sh[0]; // see [R21] see [R23]
            sh <= sh >> 1;
            bitcnt <= bitcnt + 7'h1;
          end
        end
        default: kstate <= LK_IDLE;
      endcase
    end
  end
endmodule // rcr_core

// file: core/rcr_pkg.sv
// Purpose: Types and cipher stand-ins for the receiver core.
// Assumes: Frame fields as received from the radio front end.
// Notes: The cipher functions are simple stand-ins only.
package rcr_pkg;
  typedef struct packed {
    logic [3:0] button_function_code;
    logic repeat_press;
    logic low_battery_flag;
    logic [27:0] serial;
    logic [31:0] hop;
  } rcr_frame_t;

  typedef enum logic [1:0] {LN_IDLE, LN_FIRST, LN_SECOND} rcr_learn_t;
  typedef enum logic [0:0] {V_IDLE, V_SCAN} rcr_val_t;
  typedef enum logic [1:0] {LK_IDLE, LK_NOTIFY, LK_SHIFT} rcr_link_t;

  function automatic logic [31:0] rcr_decrypt(logic [63:0] key, logic [31:0] hop);
    return hop ^ key[31:0] ^ {key[47:32], key[63:48]};
  endfunction

  function automatic logic [63:0] rcr_keygen(logic [63:0] mfr, logic [27:0] ser,
                                             logic [31:0] seed, logic secure);
    if (secure) return mfr ^ {seed, 4'h0, ser};
    return mfr ^ {ser, 8'h00, ser};
  endfunction
endpackage

// file: tb/rcr_core_sva.sv
// Purpose: Assertions on bus timing and the host link of rcr_core.
// Assumes: Bound to rcr_core; link edges are seen by sampling on clk.
// Notes: Counters bound the notify, idle and bit figures.
`timescale 1ns/1ps
module rcr_core_sva #(
  parameter int NOTIFY_CYC = 1000,
  parameter int IDLE_CYC = 200,
  parameter int ACK_CYC = 50
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic host_serial_clk,
  input wire logic host_serial_data_out,
  input wire logic host_serial_data_oe
);
  logic clk_q;
  logic rise;
  logic [6:0] rises;
  logic [3:0] since;
  logic [31:0] lo_cnt;
  logic [31:0] hi_cnt;
  assign rise = host_serial_clk && !clk_q;
  // =====
  // Link observation
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clk_q <= 1'b0;
      rises <= 7'h00;
      since <= 4'hF;
      lo_cnt <= 32'h0;
      hi_cnt <= 32'h0;
    end else begin
      clk_q <= host_serial_clk;
      rises <= host_serial_data_oe ? rises + {6'h00, rise} : 7'h00;
      since <= rise ? 4'h0 : (since == 4'hF ? since : since + 4'h1);
      lo_cnt <= (host_serial_data_oe && rises != 7'h00 && !host_serial_clk) ? lo_cnt + 1 : 0;
      hi_cnt <= (host_serial_data_oe && host_serial_data_out && !host_serial_clk) ? hi_cnt + 1 : 0;
    end
  end
  // =====
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");
  learn_ack_a: assert property (avs_write && !avs_waitrequest && avs_address[4:2] == 3'h1 &&
    avs_writedata[7:0] == 8'hD2 |-> ##[1:3] host_serial_data_oe && host_serial_data_out)
    else $error("learn command not acknowledged");
  notify_high_a: assert property ($rose(host_serial_data_oe) |-> host_serial_data_out)
    else $error("link taken without data high");
  notify_len_a: assert property (hi_cnt <= NOTIFY_CYC + ACK_CYC + 8)
    else $error("data held high too long");
  ack_drop_a: assert property (host_serial_data_out && rises == 7'h00 && rise &&
    host_serial_data_oe |-> ##[1:6] !host_serial_data_out)
    else $error("host clock rise not answered by data low");
  idle_end_a: assert property (lo_cnt <= IDLE_CYC + 8)
    else $error("transfer not ended after idle clock");
  bit_limit_a: assert property (rises <= 7'd82)
    else $error("too many bits supplied");
  bit_time_a: assert property (host_serial_data_oe && $past(host_serial_data_oe) &&
    rises != 7'h00 && $changed(host_serial_data_out) |-> since <= 4'h7)
    else $error("data changed away from a clock rise");
endmodule // rcr_core_sva

bind rcr_core rcr_core_sva #(.NOTIFY_CYC(NOTIFY_CYC), .IDLE_CYC(IDLE_CYC), .ACK_CYC(ACK_CYC))
  u_rcr_core_sva (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .host_serial_clk(host_serial_clk), .host_serial_data_out(host_serial_data_out),
  .host_serial_data_oe(host_serial_data_oe));

// file: tb/rcr_core_tb_top.sv
// Purpose: Self-checking bench for rcr_core: learn, windows, link reads, erase.
// Assumes: Shortened timing parameters; the host model drives the link clock.
// Notes: Frames are built here with the bench's own copy of the stand-in cipher.
`timescale 1ns/1ps
module rcr_core_tb_top;
  import rcr_pkg::*;
  localparam int IDLE = 200;
  localparam int ACKC = 50;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rx_valid = 1'b0;
  logic rx_intact = 1'b1;
  rcr_frame_t rx_frame = '0;
  logic sclk;
  logic sdat;
  logic dout;
  logic oe;
  logic flip = 1'b0;
  logic sec = 1'b0;
  logic [31:0] sd;
  logic [63:0] mfr;
  logic [27:0] ser;
  logic [15:0] c0;
  logic [3:0] btn;
  logic [80:0] seen;
  logic [80:0] m;
  logic [80:0] exp_q[$];
  logic [15:0] rej[3] = '{16'd27, 16'd20, 16'd16411};
  event got;
  int errors = 0;
  int check_count = 0;
  integer seed = 28668;
  always #10 clk = ~clk;
  // A released data line shows a changing pattern, not the last value.
  always @(posedge clk) flip <= ~flip;
  assign sdat = oe ? dout : flip;
  rcr_core #(.LEARN_TO_CYC(2000), .NOTIFY_CYC(1000), .IDLE_CYC(IDLE), .ACK_CYC(ACKC)) u_rcr_core (
    .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_intact(rx_intact),
    .rx_frame(rx_frame), .host_serial_clk(sclk), .host_serial_data_in(sdat),
    .host_serial_data_out(dout), .host_serial_data_oe(oe));
  rcr_host_model u_rcr_host_model (.clk(clk), .sdat(sdat), .notify(oe && dout), .sclk(sclk));
  // =====
  // Tasks
  task check(input logic [80:0] s, input logic [80:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // For a read, d is the mask applied to the read data.
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    if (!wr) begin
      seen = {49'h0, avs_readdata & d};
      -> got;
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task send(input logic [15:0] c, input logic ok);
    logic [63:0] k;
    logic [31:0] p;
    k = sec ? mfr ^ {sd, 4'h0, ser} : mfr ^ {ser, 8'h00, ser};
    p = {6'h00, ser[9:0], c};
    btn = 4'($random(seed));
    @(posedge clk);
    rx_intact <= ok;
    rx_frame <= {btn, 1'b0, 1'b1, ser, p ^ k[31:0] ^ {k[47:32], k[63:48]}};
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  task take(input int n, input logic [79:0] e);
    exp_q.push_back({e, 1'b0} & ((81'h1 << (n + 1)) - 81'h1));
    u_rcr_host_model.fetch(n, {$random(seed)} % 20, m);
    seen = m;
    -> got;
    repeat (IDLE + 20) @(posedge clk);
    check({80'h0, oe}, 81'h0);
  endtask
  task acc(input int n, input logic [15:0] c);
    send(c, 1'b1);
    take(n, {btn, ser, 6'h00, ser[9:0], c, 8'h01, 1'b1, btn, 1'b1, 1'b0, 1'b0});
  endtask
  always @(got) check(seen, exp_q.pop_front());
  // =====
  // Main sequence
  initial begin
    mfr = {$random(seed), $random(seed)};
    ser = 28'($random(seed));
    c0 = 16'hFFF0 | 16'($random(seed) & 7);
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b1, 5'h08, mfr[31:0]);
    bus(1'b1, 5'h0C, mfr[63:32]);
    exp_q.push_back(81'h0);
    bus(1'b0, 5'h14, 32'hFFFFFFFF);
    bus(1'b1, 5'h04, 32'h000000D2);
    repeat (3) @(posedge clk);
    check({79'h0, oe, dout}, 81'h3);
    repeat (ACKC + 10) @(posedge clk);
    send(c0, 1'b1);
    send(c0 + 16'd1, 1'b1);
    take(16, 80'h0182);
    exp_q.push_back(81'h1);
    bus(1'b0, 5'h04, 32'h0000000F);
    acc(80, c0 + 16'd11);
    acc(80, c0 + 16'd27);
    send(c0 + 16'd28, 1'b0);
    check({80'h0, oe}, 81'h0);
    foreach (rej[i]) begin
      send(c0 + rej[i], 1'b1);
      check({80'h0, oe}, 81'h0);
    end
    send(c0 + 16'd44, 1'b1);
    check({80'h0, oe}, 81'h0);
    acc(16, c0 + 16'd45);
    bus(1'b1, 5'h04, 32'h000000C3);
    exp_q.push_back(81'h0);
    bus(1'b0, 5'h04, 32'h0000000F);
    send(c0 + 16'd46, 1'b1);
    check({80'h0, oe}, 81'h0);
    // Secure learn: the second frame carries the seed in its hopping field.
    sec = 1'b1;
    sd = $random(seed);
    bus(1'b1, 5'h00, 32'h00000001);
    bus(1'b1, 5'h04, 32'h000000D2);
    repeat (ACKC + 10) @(posedge clk);
    send(c0, 1'b1);
    @(posedge clk);
    rx_frame <= {4'h0, 1'b0, 1'b1, ser, sd};
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    take(16, 80'h0182);
    acc(16, c0 + 16'd1);
    give_verdict;
  end
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    give_verdict;
  end
endmodule // rcr_core_tb_top

// file: tb/rcr_host_model.sv
// Purpose: Host side of the link that answers a notify and reads a message.
// Assumes: The bench resolves the data wire and feeds it in.
// Notes: The link clock stands low between messages; dly makes a slow host.
`timescale 1ns/1ps
module rcr_host_model (
  input wire logic clk,
  input wire logic sdat,
  input wire logic notify,
  output logic sclk
);
  initial sclk = 1'b0;
  // =====
  // Message fetch
  task automatic fetch(input int n, input int dly, output logic [80:0] m);
    int t;
    m = 81'h1;
    t = 0;
    while (notify !== 1'b1 && t < 400) begin
      @(posedge clk);
      t++;
    end
    repeat (dly) @(posedge clk);
    for (int i = 0; i <= n; i++) begin
      #7 sclk = 1'b1;
      #110 sclk = 1'b0;
      m[i] = sdat;
      #43;
    end
  endtask
endmodule // rcr_host_model
